// File: hw/mefc_pkg.sv
// Package with register map, field layout, reset values and timing counts of the event filter and chopper block.
package mefc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] MEFC_ADDR_FILTER = 4'h0;
  localparam logic [3:0] MEFC_ADDR_REF    = 4'h1;
  localparam logic [3:0] MEFC_ADDR_PWM    = 4'h2;
  localparam logic [3:0] MEFC_ADDR_CTRL   = 4'h3;

  localparam logic [7:0] MEFC_RST_FILTER  = 8'h0f;
  localparam logic [7:0] MEFC_RST_REF     = 8'h00;
  localparam logic [7:0] MEFC_RST_PWM     = 8'h00;
  localparam logic [7:0] MEFC_RST_CTRL    = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MEFC_FLT_SAMPLE_LSB = 4;
  localparam int MEFC_FLT_WINDOW_LSB = 0;
  localparam int MEFC_REF_BEMF_BIT   = 7;
  localparam int MEFC_REF_CUR_BIT    = 6;
  localparam int MEFC_REF_SEL_BIT    = 5;
  localparam int MEFC_REF_MODE_LSB   = 3;
  localparam int MEFC_REF_FREQ_LSB   = 0;
  localparam int MEFC_PWM_RES_BIT    = 7;
  localparam int MEFC_PWM_U_BIT      = 6;
  localparam int MEFC_PWM_V_BIT      = 5;
  localparam int MEFC_PWM_ALIGN_BIT  = 3;
  localparam int MEFC_PWM_PRE_LSB    = 0;
  localparam int MEFC_CTRL_SENSOR_BIT = 0;
  localparam int MEFC_CTRL_SLOW_BIT   = 1;

  localparam logic [15:0] MEFC_MASK_STANDARD = 16'hfff8;
  localparam logic [15:0] MEFC_MASK_8BIT     = 16'hff00;

  typedef enum logic [1:0] {
    MEFC_CHOP_OFF,
    MEFC_CHOP_LOW,
    MEFC_CHOP_HIGH,
    MEFC_CHOP_BOTH
  } mefc_chop_mode_t;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int MEFC_CLK_FREQ_KHZ   = 10000;
  localparam int MEFC_CLK_PERIOD_NS  = 100;
  localparam int MEFC_BLANK_STEP_A_NS = 5000;
  localparam int MEFC_BLANK_BASE_B_NS = 60000;
  localparam int MEFC_BLANK_STEP_B_NS = 20000;
  localparam int MEFC_BLANK_CNT_W    = 11;

  localparam int MEFC_CHOP_KHZ_0 = 100;
  localparam int MEFC_CHOP_KHZ_1 = 200;
  localparam int MEFC_CHOP_KHZ_2 = 400;
  localparam int MEFC_CHOP_KHZ_3 = 500;
  localparam int MEFC_CHOP_KHZ_4 = 800;
  localparam int MEFC_CHOP_KHZ_5 = 1000;
  localparam int MEFC_CHOP_KHZ_6 = 1333;
  localparam int MEFC_CHOP_KHZ_7 = 2000;

  // Blanking window length in clock cycles for a window code.
  function automatic logic [MEFC_BLANK_CNT_W-1:0] mefc_blank_cycles(input logic [3:0] code);
    int t_ns;
    if (code[3] == 1'b0) begin
      t_ns = MEFC_BLANK_STEP_A_NS * (int'(code) + 1);
    end else begin
      t_ns = MEFC_BLANK_BASE_B_NS + MEFC_BLANK_STEP_B_NS * (int'(code) - 8);
    end
    mefc_blank_cycles = MEFC_BLANK_CNT_W'(t_ns / MEFC_CLK_PERIOD_NS);
  endfunction

  // Chopper half period in clock cycles, rounded down, at least one.
  function automatic logic [7:0] mefc_chop_half(input logic [2:0] code, input logic slow);
    int f_khz;
    int h;
    case (code)
      3'h0: f_khz = MEFC_CHOP_KHZ_0;
      3'h1: f_khz = MEFC_CHOP_KHZ_1;
      3'h2: f_khz = MEFC_CHOP_KHZ_2;
      3'h3: f_khz = MEFC_CHOP_KHZ_3;
      3'h4: f_khz = MEFC_CHOP_KHZ_4;
      3'h5: f_khz = MEFC_CHOP_KHZ_5;
      3'h6: f_khz = MEFC_CHOP_KHZ_6;
      default: f_khz = MEFC_CHOP_KHZ_7;
    endcase
    if (slow) begin
      f_khz = f_khz / 2;
    end
    h = MEFC_CLK_FREQ_KHZ / (2 * f_khz);
    if (h < 1) begin
      h = 1;
    end
    mefc_chop_half = 8'(h);
  endfunction

endpackage

// File: hw/mefc_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module mefc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule // mefc_sync

// File: hw/mefc_top.sv
// Event filter, blanking window, comparator reference, chopper and PWM control register block.
//
// Operation
// - Event needs filter field plus one unbroken valid samples; sensor mode needs one.
// - A blanking window that hides event detection starts at every commutation event outside sensor mode.
// - Window codes 0-7 give 5-40us in 5us steps, 8-15 give 60-200us in 20us.
// - With sensor mode selected, commutation starts no blanking window at all.
// - Window times are realised as clock-cycle counts derived from the clock rate.
// - Reference register bit 7 reads the live back-EMF comparator output.
// - Reference register bit 6 reads the live current comparator output.
// - Reference bit 5 picks the current input: 0 amplifier, 1 direct sense.
// - Chop mode 00 off, 01 low side, 10 high side, 11 both sides.
// - Chop frequency code picks 100kHz to 2MHz, halved with the slow controller clock.
// - The chopper waveform has a 50 percent duty cycle.
// - Resolution mode picks active compare bits 15:3 or 15:8.
// - Phase U full-duty bit forces 100 percent duty for one update period.
// - Phase V full-duty bit forces 100 percent duty for one update period.
// - Full-duty bits clear themselves once moved to the active register.
// - PWM control bit 3 selects edge or center aligned counting.
// - PWM control bits 2:0 divide the counter clock by code plus one.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module mefc_top (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [7:0]  rd_data_o,
  input  wire logic        demag_sample_i,
  input  wire logic        sample_en_i,
  input  wire logic        comm_event_i,
  input  wire logic        update_event_i,
  input  wire logic        bemf_comparator_i,
  input  wire logic        current_sense_direct_in_i,
  input  wire logic        current_sense_amp_in_i,
  output logic             demag_event_o,
  output logic             blank_active_o,
  output logic             current_comparator_out_o,
  output logic             chop_high_o,
  output logic             chop_low_o,
  output logic             phase_u_full_duty_o,
  output logic             phase_v_full_duty_o,
  output logic             counter_alignment_o,
  output logic             pwm_count_tick_o,
  output logic      [15:0] compare_active_mask_o
);
  import mefc_pkg::*;
  default clocking cb_sys @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       demag_s;
  logic       bemf_s;
  logic       cur_direct_s;
  logic       cur_amp_s;

  mefc_sync #(.WIDTH(4)) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   ({demag_sample_i, bemf_comparator_i, current_sense_direct_in_i, current_sense_amp_in_i}),
    .sync_o    (pins_s)
  );

  assign {demag_s, bemf_s, cur_direct_s, cur_amp_s} = pins_s;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0]  filter_reg, filter_next;
  logic [5:0]  ref_reg, ref_next;
  logic [7:0]  pwm_reg, pwm_next;
  logic [1:0]  ctrl_reg, ctrl_next;
  logic        u_act_reg, u_act_next;
  logic        v_act_reg, v_act_next;
  logic        cur_cmp_reg, cur_cmp_next;
  logic [15:0] mask_reg, mask_next;
  logic [7:0]  rd_data_reg, rd_data_next;
  logic        wr_pwm;
  logic        sensor;
  logic        slow_clk;
  logic [3:0]  win_code;
  logic [3:0]  flt_code;
  logic [MEFC_BLANK_CNT_W-1:0] blank_cnt_reg, blank_cnt_next;
  logic [3:0]  filter_cnt_reg, filter_cnt_next;
  logic        event_reg, event_next;
  logic        blank_act_reg, blank_act_next;

  assign wr_pwm   = wr_en_i && (addr_i == MEFC_ADDR_PWM);
  assign sensor   = ctrl_reg[MEFC_CTRL_SENSOR_BIT];
  assign slow_clk = ctrl_reg[MEFC_CTRL_SLOW_BIT];
  assign win_code = filter_reg[MEFC_FLT_WINDOW_LSB +: 4];
  assign flt_code = filter_reg[MEFC_FLT_SAMPLE_LSB +: 4];

  always_comb begin
    filter_next  = filter_reg;
    ref_next     = ref_reg;
    pwm_next     = pwm_reg;
    ctrl_next    = ctrl_reg;
    u_act_next   = u_act_reg;
    v_act_next   = v_act_reg;
    rd_data_next = 8'h00;
    if (update_event_i) begin
      u_act_next = pwm_reg[MEFC_PWM_U_BIT];
      v_act_next = pwm_reg[MEFC_PWM_V_BIT];
      pwm_next[MEFC_PWM_U_BIT] = 1'b0;
      pwm_next[MEFC_PWM_V_BIT] = 1'b0;
    end
    if (wr_en_i) begin
      case (addr_i)
        MEFC_ADDR_FILTER: filter_next = wr_data_i;
        MEFC_ADDR_REF:    ref_next    = wr_data_i[5:0];
        MEFC_ADDR_PWM:    pwm_next    = wr_data_i;
        MEFC_ADDR_CTRL:   ctrl_next   = wr_data_i[1:0];
        default: ;
      endcase
    end
    if (rd_en_i) begin
      case (addr_i)
        MEFC_ADDR_FILTER: rd_data_next = filter_reg;
        MEFC_ADDR_REF:    rd_data_next = {bemf_s, cur_cmp_reg, ref_reg};
        MEFC_ADDR_PWM:    rd_data_next = pwm_reg;
        MEFC_ADDR_CTRL:   rd_data_next = {v_act_reg, u_act_reg, (blank_cnt_reg != '0), (filter_cnt_reg != 4'h0),
                                          2'b00, ctrl_reg};
        default:          rd_data_next = 8'h00;
      endcase
    end
    cur_cmp_next = ref_reg[MEFC_REF_SEL_BIT] ? cur_direct_s : cur_amp_s;
    mask_next    = pwm_next[MEFC_PWM_RES_BIT] ? MEFC_MASK_8BIT : MEFC_MASK_STANDARD;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      filter_reg  <= MEFC_RST_FILTER;
      ref_reg     <= MEFC_RST_REF[5:0];
      pwm_reg     <= MEFC_RST_PWM;
      ctrl_reg    <= MEFC_RST_CTRL[1:0];
      u_act_reg   <= 1'b0;
      v_act_reg   <= 1'b0;
      cur_cmp_reg <= 1'b0;
      mask_reg    <= MEFC_MASK_STANDARD;
      rd_data_reg <= 8'h00;
    end else begin
      filter_reg  <= filter_next;
      ref_reg     <= ref_next;
      pwm_reg     <= pwm_next;
      ctrl_reg    <= ctrl_next;
      u_act_reg   <= u_act_next;
      v_act_reg   <= v_act_next;
      cur_cmp_reg <= cur_cmp_next;
      mask_reg    <= mask_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Blanking window and event filter
  // ---------------------------------------------------------------------------
  always_comb begin
    blank_cnt_next  = blank_cnt_reg;
    filter_cnt_next = filter_cnt_reg;
    event_next      = 1'b0;
    if (comm_event_i) begin
      blank_cnt_next = sensor ? '0 : mefc_blank_cycles(win_code);
    end else if (blank_cnt_reg != '0) begin
      blank_cnt_next = blank_cnt_reg - 1'b1;
    end
    blank_act_next = (blank_cnt_next != '0);
    if (comm_event_i || (blank_cnt_reg != '0)) begin
      filter_cnt_next = 4'h0;
    end else if (sample_en_i) begin
      if (!demag_s) begin
        filter_cnt_next = 4'h0;
      end else if (sensor || (filter_cnt_reg == flt_code)) begin
        event_next      = 1'b1;
        filter_cnt_next = 4'h0;
      end else begin
        filter_cnt_next = filter_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      blank_cnt_reg  <= '0;
      filter_cnt_reg <= 4'h0;
      event_reg      <= 1'b0;
      blank_act_reg  <= 1'b0;
    end else begin
      blank_cnt_reg  <= blank_cnt_next;
      filter_cnt_reg <= filter_cnt_next;
      event_reg      <= event_next;
      blank_act_reg  <= blank_act_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Chopper and PWM counter prescaler
  // ---------------------------------------------------------------------------
  logic [7:0] chop_cnt_reg, chop_cnt_next;
  logic       chop_phase_reg, chop_phase_next;
  logic       chop_high_reg, chop_high_next;
  logic       chop_low_reg, chop_low_next;
  logic [7:0] chop_half_m1;
  logic [1:0] chop_mode;
  logic [2:0] pre_cnt_reg, pre_cnt_next;
  logic       tick_reg, tick_next;

  assign chop_mode    = ref_reg[MEFC_REF_MODE_LSB +: 2];
  assign chop_half_m1 = mefc_chop_half(ref_reg[MEFC_REF_FREQ_LSB +: 3], slow_clk) - 8'h01;

  always_comb begin
    chop_cnt_next   = chop_cnt_reg;
    chop_phase_next = chop_phase_reg;
    if (mefc_chop_mode_t'(chop_mode) == MEFC_CHOP_OFF) begin
      chop_cnt_next   = 8'h00;
      chop_phase_next = 1'b0;
    end else if (chop_cnt_reg == 8'h00) begin
      chop_cnt_next   = chop_half_m1;
      chop_phase_next = !chop_phase_reg;
    end else begin
      chop_cnt_next = chop_cnt_reg - 8'h01;
    end
    chop_high_next = chop_phase_next && chop_mode[1];
    chop_low_next  = chop_phase_next && chop_mode[0];
    if (pre_cnt_reg >= pwm_reg[MEFC_PWM_PRE_LSB +: 3]) begin
      pre_cnt_next = 3'h0;
      tick_next    = 1'b1;
    end else begin
      pre_cnt_next = pre_cnt_reg + 3'h1;
      tick_next    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      chop_cnt_reg   <= 8'h00;
      chop_phase_reg <= 1'b0;
      chop_high_reg  <= 1'b0;
      chop_low_reg   <= 1'b0;
      pre_cnt_reg    <= 3'h0;
      tick_reg       <= 1'b0;
    end else begin
      chop_cnt_reg   <= chop_cnt_next;
      chop_phase_reg <= chop_phase_next;
      chop_high_reg  <= chop_high_next;
      chop_low_reg   <= chop_low_next;
      pre_cnt_reg    <= pre_cnt_next;
      tick_reg       <= tick_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rd_data_o                = rd_data_reg;
  assign demag_event_o            = event_reg;
  assign blank_active_o           = blank_act_reg;
  assign current_comparator_out_o = cur_cmp_reg;
  assign chop_high_o              = chop_high_reg;
  assign chop_low_o               = chop_low_reg;
  assign phase_u_full_duty_o      = u_act_reg;
  assign phase_v_full_duty_o      = v_act_reg;
  assign counter_alignment_o      = pwm_reg[MEFC_PWM_ALIGN_BIT];
  assign pwm_count_tick_o         = tick_reg;
  assign compare_active_mask_o    = mask_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_blank_load;
    (comm_event_i && !sensor) |=> (blank_cnt_reg == mefc_blank_cycles($past(win_code)));
  endproperty
  a_blank_load: assert property (p_blank_load) else $error("Blank window not loaded on commutation.");
  property p_blank_sensor;
    (comm_event_i && sensor) |=> !blank_active_o;
  endproperty
  a_blank_sensor: assert property (p_blank_sensor) else $error("Blanking applied in sensor mode.");
  property p_blank_discard;
    (blank_cnt_reg != '0) |=> !demag_event_o && (filter_cnt_reg == 4'h0);
  endproperty
  a_blank_discard: assert property (p_blank_discard) else $error("Sample accepted inside window.");
  property p_blank_run;
    (blank_active_o && !comm_event_i) |=> (blank_cnt_reg == $past(blank_cnt_reg) - 1'b1);
  endproperty
  a_blank_run: assert property (p_blank_run) else $error("Blank window did not count down.");
  property p_filter_restart;
    (sample_en_i && !demag_s) |=> (filter_cnt_reg == 4'h0) && !demag_event_o;
  endproperty
  a_filter_restart: assert property (p_filter_restart) else $error("Invalid sample kept the count.");
  property p_filter_fire;
    (sample_en_i && demag_s && !comm_event_i && !blank_active_o && !sensor && (filter_cnt_reg == flt_code))
      |=> demag_event_o;
  endproperty
  a_filter_fire: assert property (p_filter_fire) else $error("Event missing after full sample run.");
  property p_ref_read;
    (rd_en_i && (addr_i == MEFC_ADDR_REF)) |=> (rd_data_o[7] == $past(bemf_s)) && (rd_data_o[6] == $past(cur_cmp_reg));
  endproperty
  a_ref_read: assert property (p_ref_read) else $error("Live comparator bits wrong on read.");
  property p_cur_select;
    ##1 (current_comparator_out_o == ($past(ref_reg[MEFC_REF_SEL_BIT]) ? $past(cur_direct_s) : $past(cur_amp_s)));
  endproperty
  a_cur_select: assert property (p_cur_select) else $error("Current comparator input select wrong.");
  property p_chop_off;
    (chop_mode == 2'b00) |=> !chop_high_o && !chop_low_o;
  endproperty
  a_chop_off: assert property (p_chop_off) else $error("Chopper active while off.");
  property p_chop_reload;
    ((chop_mode != 2'b00) && (chop_cnt_reg == 8'h00)) |=> (chop_cnt_reg == $past(chop_half_m1)) && $changed(chop_phase_reg);
  endproperty
  a_chop_reload: assert property (p_chop_reload) else $error("Chopper half period wrong.");
  property p_full_u;
    (update_event_i && !wr_pwm) |=> (phase_u_full_duty_o == $past(pwm_reg[MEFC_PWM_U_BIT])) && !pwm_reg[MEFC_PWM_U_BIT];
  endproperty
  a_full_u: assert property (p_full_u) else $error("Phase U full duty transfer wrong.");
  property p_full_v;
    (update_event_i && !wr_pwm) |=> (phase_v_full_duty_o == $past(pwm_reg[MEFC_PWM_V_BIT])) && !pwm_reg[MEFC_PWM_V_BIT];
  endproperty
  a_full_v: assert property (p_full_v) else $error("Phase V full duty transfer wrong.");
  property p_pwm_write;
    wr_pwm |=> (counter_alignment_o == $past(wr_data_i[MEFC_PWM_ALIGN_BIT]))
      && (compare_active_mask_o == ($past(wr_data_i[MEFC_PWM_RES_BIT]) ? MEFC_MASK_8BIT : MEFC_MASK_STANDARD));
  endproperty
  a_pwm_write: assert property (p_pwm_write) else $error("Alignment or resolution mode not applied.");
  property p_prescale;
    (pwm_count_tick_o && (pwm_reg[2:0] != 3'h0) && !wr_pwm) |=> !pwm_count_tick_o;
  endproperty
  a_prescale: assert property (p_prescale) else $error("Prescaler tick too early.");
  c_event: cover property (@(posedge sys_clk_i) disable iff (reset_i) demag_event_o && !sensor);
  c_blank_end: cover property (@(posedge sys_clk_i) disable iff (reset_i) $fell(blank_active_o));
  c_full_u: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(phase_u_full_duty_o));
  c_chop_both: cover property (@(posedge sys_clk_i) disable iff (reset_i) chop_high_o && chop_low_o);
endmodule // mefc_top

// File: dv/mefc_partner.sv
// Model of the motor sense comparators that feed the block's pins.
`timescale 1ns/10ps
module mefc_partner (
  input  wire logic       sys_clk_i,
  input  wire logic [2:0] level_i,
  output logic            bemf_o,
  output logic            direct_o,
  output logic            amp_o
);
  // ---------------------------------------------------------------------------
  // Comparator outputs
  // ---------------------------------------------------------------------------
  // Outputs settle just after each clock edge, as the analogue comparators would.
  initial begin
    {bemf_o, direct_o, amp_o} = 3'h0;
  end
  always @(posedge sys_clk_i) begin
    {bemf_o, direct_o, amp_o} <= level_i;
  end
endmodule // mefc_partner

// File: dv/mefc_tb_top.sv
// Self-checking testbench of the event filter, blanking, chopper and PWM control block.
`timescale 1ns/10ps
module mefc_tb_top;
  import mefc_pkg::*;
  logic        sys_clk_i = 0, reset_i = 1, wr_en_i = 0, rd_en_i = 0, demag_sample_i = 0, sample_en_i = 0;
  logic        comm_event_i = 0, update_event_i = 0, bemf_comparator_i, current_sense_direct_in_i;
  logic        current_sense_amp_in_i, demag_event_o, blank_active_o, current_comparator_out_o, chop_high_o;
  logic        chop_low_o, phase_u_full_duty_o, phase_v_full_duty_o, counter_alignment_o, pwm_count_tick_o, hi, lo;
  logic [3:0]  addr_i = 0;
  logic [7:0]  wr_data_i = 0, rd_data_o;
  logic [2:0]  lvl = 0;
  logic [15:0] compare_active_mask_o;
  logic [19:0] rows [5] = '{20'h0a5a5, 20'h1ff3f, 20'h24848, 20'h7ff00, 20'h3ff03};
  logic [1:0]  fseq [6] = '{2'b10, 2'b10, 2'b00, 2'b10, 2'b10, 2'b11};
  int          hs [8] = '{50, 25, 12, 10, 6, 5, 3, 2};
  int          fails = 0, n_compared = 0, n, h, l;

  mefc_top dut (.sys_clk_i, .reset_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .demag_sample_i,
    .sample_en_i, .comm_event_i, .update_event_i, .bemf_comparator_i, .current_sense_direct_in_i,
    .current_sense_amp_in_i, .demag_event_o, .blank_active_o, .current_comparator_out_o, .chop_high_o,
    .chop_low_o, .phase_u_full_duty_o, .phase_v_full_duty_o, .counter_alignment_o, .pwm_count_tick_o,
    .compare_active_mask_o);
  mefc_partner u_part (.sys_clk_i, .level_i(lvl), .bemf_o(bemf_comparator_i),
    .direct_o(current_sense_direct_in_i), .amp_o(current_sense_amp_in_i));

  always #50 sys_clk_i = ~sys_clk_i;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkn(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      fails++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    tick();
    wr_en_i <= 1'b0;
    tick();
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_en_i <= 1'b1;
    tick();
    rd_en_i <= 1'b0;
    chk("rd_data", {8'h00, e}, {8'h00, rd_data_o});
    tick();
  endtask
  task automatic smp(input logic v, input logic e);
    demag_sample_i <= v;
    repeat (3) tick();
    sample_en_i <= 1'b1;
    tick();
    sample_en_i <= 1'b0;
    chk("demag_event", {15'h0, e}, {15'h0, demag_event_o});
  endtask
  task automatic blank(input logic [3:0] c, input int e);
    wr(MEFC_ADDR_FILTER, {4'h0, c});
    comm_event_i <= 1'b1;
    tick();
    comm_event_i <= 1'b0;
    n = 0;
    while (blank_active_o === 1'b1 && n < 3000) begin
      n++;
      tick();
    end
    chkn("blank_len", e, n);
  endtask
  task automatic half();
    h = 0;
    l = 0;
    n = 0;
    while (chop_low_o !== 1'b0 && n < 300) begin n++; tick(); end
    while (chop_low_o !== 1'b1 && n < 600) begin n++; tick(); end
    while (chop_low_o === 1'b1 && h < 300) begin h++; tick(); end
    while (chop_low_o === 1'b0 && l < 300) begin l++; tick(); end
  endtask
  task automatic upd(input logic [1:0] e);
    update_event_i <= 1'b1;
    tick();
    update_event_i <= 1'b0;
    tick();
    chk("full_uv", {14'h0, e}, {14'h0, phase_u_full_duty_o, phase_v_full_duty_o});
  endtask
  task automatic rst();
    reset_i <= 1'b1;
    repeat (5) tick();
    reset_i <= 1'b0;
    tick();
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    fails++;
    wrap_up();
  end

  initial begin
    rst();
    chk("mask", 16'hfff8, compare_active_mask_o);
    rd(MEFC_ADDR_FILTER, MEFC_RST_FILTER);
    rd(MEFC_ADDR_REF, MEFC_RST_REF);
    rd(MEFC_ADDR_PWM, MEFC_RST_PWM);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0]);
    end
    wr(MEFC_ADDR_CTRL, 8'h00);
    wr(MEFC_ADDR_FILTER, 8'h20);
    foreach (fseq[i]) smp(fseq[i][1], fseq[i][0]);
    wr(MEFC_ADDR_CTRL, 8'h01);
    smp(1'b1, 1'b1);
    blank(4'h3, 0);
    wr(MEFC_ADDR_CTRL, 8'h00);
    foreach (hs[i]) blank(4'(i * 2 + 1), i < 4 ? (i * 2 + 2) * 50 : 600 + (i * 2 - 7) * 200);
    blank(4'h0, 50);
    wr(MEFC_ADDR_FILTER, 8'h00);
    comm_event_i <= 1'b1;
    tick();
    comm_event_i <= 1'b0;
    smp(1'b1, 1'b0);
    repeat (50) tick();
    smp(1'b1, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(MEFC_ADDR_REF, {3'h0, 2'(m), 3'h7});
      repeat (4) tick();
      hi = 0;
      lo = 0;
      repeat (6) begin tick(); hi |= chop_high_o; lo |= chop_low_o; end
      chk("chop_sides", 16'(m), {14'h0, hi, lo});
    end
    foreach (hs[i]) begin
      wr(MEFC_ADDR_REF, {3'h0, 2'h3, 3'(i)});
      half();
      chkn("chop_high", hs[i], h);
      chkn("chop_low", hs[i], l);
    end
    wr(MEFC_ADDR_REF, 8'h18);
    wr(MEFC_ADDR_CTRL, 8'h02);
    half();
    chkn("chop_slow", 100, h);
    lvl <= 3'b101;
    wr(MEFC_ADDR_REF, 8'h00);
    repeat (6) tick();
    chk("cur_out", 16'h1, {15'h0, current_comparator_out_o});
    rd(MEFC_ADDR_REF, 8'hc0);
    wr(MEFC_ADDR_REF, 8'h20);
    repeat (6) tick();
    chk("cur_out", 16'h0, {15'h0, current_comparator_out_o});
    rd(MEFC_ADDR_REF, 8'ha0);
    wr(MEFC_ADDR_PWM, 8'h40);
    upd(2'b10);
    wr(MEFC_ADDR_PWM, 8'h20);
    upd(2'b01);
    rd(MEFC_ADDR_PWM, 8'h00);
    upd(2'b00);
    wr(MEFC_ADDR_PWM, 8'h88);
    tick();
    chk("mask", 16'hff00, compare_active_mask_o);
    chk("align", 16'h1, {15'h0, counter_alignment_o});
    for (int c = 0; c < 8; c += 7) begin
      wr(MEFC_ADDR_PWM, 8'(c));
      repeat (2) tick();
      n = 0;
      repeat (40) begin tick(); n += int'(pwm_count_tick_o === 1'b1); end
      chkn("ticks", 40 / (c + 1), n);
    end
    rst();
    rd(MEFC_ADDR_FILTER, MEFC_RST_FILTER);
    wrap_up();
  end
endmodule // mefc_tb_top
